// ===== rmsp_host_model.sv
`timescale 1ns/100ps
module rmsp_host_model (
  // Clock
  input  wire logic mclk_i,
  // Serial pins
  output logic      serial_shift_clock_o,
  output logic      frame_select_n_o,
  output logic      serial_data_o,
  input  wire logic serial_data_i
);
  // Half period in mclk; slow enough for the pin filter
  localparam int HALF = 8;
  initial begin
    serial_shift_clock_o = 1'b0;
    frame_select_n_o     = 1'b1;
    serial_data_o        = 1'b0;
  end
  // One framed transaction, header then nb payload bytes
  task automatic xfer(input logic [7:0] hdr, input int nb,
                      input logic [31:0] wd, output logic [31:0] rd);
    logic [39:0] bits;
    bits = {hdr, wd};
    rd   = 32'h0;
    @(negedge mclk_i);
    frame_select_n_o = 1'b0;
    for (int i = 0; i < 8 + 8 * nb; i++) begin
      serial_data_o = bits[39 - i];
      repeat (HALF) @(negedge mclk_i);
      serial_shift_clock_o = 1'b1;
      if (i >= 8) rd = {rd[30:0], serial_data_i};
      repeat (HALF) @(negedge mclk_i);
      serial_shift_clock_o = 1'b0;
    end
    repeat (HALF) @(negedge mclk_i);
    frame_select_n_o = 1'b1;
    serial_data_o    = ~serial_data_o; // Released line shows no stale bit
    repeat (2 * HALF) @(negedge mclk_i);
  endtask : xfer
endmodule : rmsp_host_model

// ===== rmsp_pkg.sv
package rmsp_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [5:0]  ADDR_CLKOUT_TRIM  = 6'h0A;
  localparam logic [15:0] RST_CLKOUT_TRIM   = 16'h0000;

  // ------------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------------
  localparam int          TRIM_MSB          = 15;
  localparam int          TRIM_LSB          = 8;
  localparam int          CLKSEL_MSB        = 2;
  localparam int          CLKSEL_LSB        = 0;
  localparam logic [2:0]  CLKSEL_UNDIVIDED  = 3'h0;
  localparam int          HDR_RD_BIT        = 7;
  localparam int          BYTE_BITS         = 8;
  localparam int          MIN_PAYLOAD_BYTES = 2;
  localparam int          MIN_BURSTS        = 3;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int          CLK_MHZ           = 25;
  localparam int          REF_MHZ           = 16;
  localparam int          SCK_MAX_MHZ       = 8;
  localparam int          SYNC_STAGES       = 3;

  // Transaction phases
  typedef enum logic [2:0] {
    RMSP_IDLE = 3'b001,
    RMSP_HDR  = 3'b010,
    RMSP_DATA = 3'b100
  } rmsp_state_t;

endpackage : rmsp_pkg

// ===== rmsp_spi_slave.sv
`timescale 1ns/100ps

// Function
// - Slave only; host drives shift clock, modem never starts a transfer.
// - Frame select falling low starts a new transaction.
// - Data sampled on clock rise, output changes on clock fall.
// - Bursts are eight bits, most significant bit first, both directions.
// - First burst is an eight-bit header with address and direction.
// - Writes carry data in on host line, reads out on modem line.
// - Only one data direction is meaningful during any payload burst.
// - Payload is at least two bytes; longer depends on resource.
// - Frame select rising high ends the transaction.
// - Read data leave on serial output, host data enter on input.
// - Shifting needs no own clock; register moves use the core clock.
// - No reference divider; only sixteen megahertz reference assumed.
// - Eight-bit warp trim sits in bits 15..8 of register 0A.
// - Trim zero is highest frequency; larger trim lowers frequency.
// - Select field 000 puts undivided reference on clock output.
// - Port responds only in idle or active modes, not hibernate or doze; here the mode is checked only at frame start, a frame under way runs on.
module rmsp_spi_slave
  import rmsp_pkg::*;
(
  // Core clock and reset
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  // Serial pins
  input  wire logic        serial_shift_clock_i,
  input  wire logic        frame_select_n_i,
  input  wire logic        serial_data_i,
  output logic             serial_data_o,
  output logic             serial_data_oe_o,
  // Power mode: high in idle or active modes
  input  wire logic        port_awake_i,
  // Control to the oscillator and clock output mux
  output logic [7:0]       xtal_warp_trim_o,
  output logic [2:0]       clock_output_select_o,
  output logic             reference_clock_output_undivided_o,
  // Status
  output logic             busy_o,
  output logic             short_frame_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic       sck;
  logic       sel_on;
  logic       mosi;
  logic [2:0] pin_lvl;
  wire  [2:0] pin_raw = {serial_data_i, ~frame_select_n_i,
                         serial_shift_clock_i};

  // One filter per pin; select is inverted first so it idles low
  for (genvar g = 0; g < 3; g++) begin : g_sync
    rmsp_sync u_rmsp_sync (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .din_i     (pin_raw[g]),
      .level_o   (pin_lvl[g])
    );
  end

  // Same lag on every pin keeps data aligned with its clock edge
  assign sck    = pin_lvl[0];
  assign sel_on = pin_lvl[1];
  assign mosi   = pin_lvl[2];

  // ----------------------------------------------------------------
  // Edge detection on filtered levels
  // ----------------------------------------------------------------
  logic sck_d;
  logic sel_d;
  wire  selected  = sel_on;                 // Filtered select, active high
  wire  frame_beg = selected & ~sel_d;
  wire  frame_end = ~selected & sel_d;
  wire  sck_rise  = sck & ~sck_d & selected;
  wire  sck_fall  = ~sck & sck_d & selected;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sck_d <= 1'b0;
      sel_d <= 1'b0;
    end else begin
      sck_d <= sck;
      sel_d <= selected;
    end
  end

  // ----------------------------------------------------------------
  // Transaction state
  // ----------------------------------------------------------------
  rmsp_state_t state;
  rmsp_state_t next_state;
  logic [2:0]  bit_cnt;
  logic [7:0]  shift_in;
  logic [7:0]  shift_out;
  logic        is_read;
  logic [5:0]  addr;
  logic        byte_idx;                  // 0 = high byte, 1 = low byte
  logic [7:0]  hi_byte;
  logic [2:0]  burst_cnt;
  logic [15:0] ctl_reg;
  logic        active;
  logic        load_pend;
  logic [7:0]  load_byte;

  // Address decode shared by the header path and the payload path
  function automatic logic hit_ctl_hdr(input logic [5:0] a);
    hit_ctl_hdr = (a == ADDR_CLKOUT_TRIM);
  endfunction : hit_ctl_hdr

  wire  [7:0]  byte_in   = {shift_in[6:0], mosi};
  wire         byte_done = sck_rise & (bit_cnt == 3'h7);
  wire         hit_ctl   = hit_ctl_hdr(addr);
  wire  [15:0] rd_word   = hit_ctl ? ctl_reg : 16'h0000;
  wire         hdr_read  = byte_in[HDR_RD_BIT];
  wire  [5:0]  hdr_addr  = byte_in[5:0];
  wire         wr_commit = byte_done & (state == RMSP_DATA) & ~is_read
                           & byte_idx;

  // Next phase: header first, then payload until frame end
  always_comb begin
    next_state = state;
    unique case (state)
      RMSP_IDLE: begin
        if (frame_beg & port_awake_i) begin
          next_state = RMSP_HDR;
        end
      end
      RMSP_HDR: begin
        if (frame_end) begin
          next_state = RMSP_IDLE;
        end else if (byte_done) begin
          next_state = RMSP_DATA;
        end
      end
      RMSP_DATA: begin
        if (frame_end) begin
          next_state = RMSP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state <= RMSP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Bit and byte counters, input shifter
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || state == RMSP_IDLE) begin
      bit_cnt   <= 3'h0;
      shift_in  <= 8'h00;
      burst_cnt <= 3'h0;
      byte_idx  <= 1'b0;
    end else if (sck_rise) begin
      bit_cnt  <= bit_cnt + 3'h1;
      shift_in <= byte_in;
      if (bit_cnt == 3'h7) begin
        if (burst_cnt != 3'h7) begin
          burst_cnt <= burst_cnt + 3'h1;
        end
        if (state == RMSP_DATA) begin
          byte_idx <= ~byte_idx;
        end
      end
    end
  end

  // Header capture; long transfers auto-advance to the next word
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      is_read <= 1'b0;
      addr    <= 6'h00;
      hi_byte <= 8'h00;
    end else if (byte_done && state == RMSP_HDR) begin
      is_read <= hdr_read;
      addr    <= hdr_addr;
    end else if (byte_done && state == RMSP_DATA) begin
      if (!byte_idx) begin
        hi_byte <= byte_in;
      end else begin
        addr <= addr + 6'h01;
      end
    end
  end

  // Control register written in the core clock domain
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ctl_reg <= RST_CLKOUT_TRIM;
    end else if (wr_commit && hit_ctl) begin
      ctl_reg <= {hi_byte, byte_in};
    end
  end

  // Next byte is picked at the rise that ends a byte, moved in at the fall
  wire load_hi = byte_done & (state == RMSP_HDR) & hdr_read;
  wire load_lo = byte_done & (state == RMSP_DATA) & is_read & ~byte_idx;
  wire load_nx = byte_done & (state == RMSP_DATA) & is_read & byte_idx;
  wire       load_any = load_hi | load_lo | load_nx;
  wire [7:0] hi_pick  = hit_ctl_hdr(hdr_addr) ? ctl_reg[15:8] : 8'h00;
  wire [7:0] load_val = load_hi ? hi_pick
                      : (load_lo ? rd_word[7:0] : 8'h00);  // Next word's high byte is 0

  // Hold the picked byte until the fall; a rise must never move the line
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || state == RMSP_IDLE) begin
      load_pend <= 1'b0;
      load_byte <= 8'h00;
    end else if (load_any) begin
      load_pend <= 1'b1;
      load_byte <= load_val;
    end else if (sck_fall) begin
      load_pend <= 1'b0;
    end
  end

  // Output shifter changes only on a falling shift clock
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || state == RMSP_IDLE) begin
      shift_out <= 8'h00;
    end else if (sck_fall && load_pend) begin
      shift_out <= load_byte;
    end else if (sck_fall && bit_cnt != 3'h0) begin
      shift_out <= {shift_out[6:0], 1'b0};
    end
  end

  wire is_read_next = (state == RMSP_HDR) ? hdr_read : is_read;

  // Serial output only drives during read payload
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      active <= 1'b0;
    end else begin
      active <= (next_state == RMSP_DATA) & is_read_next;
    end
  end

  assign serial_data_o    = active ? shift_out[7] : 1'b0;
  assign serial_data_oe_o = active;

  // Short frame flag: fewer than three bursts seen at frame end
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      short_frame_o <= 1'b0;
    end else if (frame_end && state != RMSP_IDLE) begin
      short_frame_o <= (burst_cnt < 3'(MIN_BURSTS));
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  assign xtal_warp_trim_o      = ctl_reg[TRIM_MSB:TRIM_LSB];
  assign clock_output_select_o = ctl_reg[CLKSEL_MSB:CLKSEL_LSB];
  assign reference_clock_output_undivided_o =
    (ctl_reg[CLKSEL_MSB:CLKSEL_LSB] == CLKSEL_UNDIVIDED);
  assign busy_o                = (state != RMSP_IDLE);

endmodule : rmsp_spi_slave

// ===== rmsp_spi_slave_assertions.sv
`timescale 1ns/100ps
module rmsp_checker (
  // Clock and reset
  input wire logic       mclk_i,
  input wire logic       sys_rst_i,
  // Pins
  input wire logic       serial_shift_clock_i,
  input wire logic       frame_select_n_i,
  input wire logic       serial_data_o,
  input wire logic       serial_data_oe_o,
  input wire logic       port_awake_i,
  // Control and status
  input wire logic [7:0] xtal_warp_trim_o,
  input wire logic [2:0] clock_output_select_o,
  input wire logic       reference_clock_output_undivided_o,
  input wire logic       busy_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // Eight idle cycles cover the pin filter lag with margin
  a_undiv_decode: assert property (
    reference_clock_output_undivided_o == (clock_output_select_o == 3'h0))
    else $error("undivided flag does not follow select");
  a_no_drive_idle: assert property (
    frame_select_n_i [*8] |-> !serial_data_oe_o)
    else $error("output driven outside a frame");
  a_quiet_low: assert property (
    !serial_data_oe_o |-> serial_data_o == 1'b0)
    else $error("data out not low while released");
  a_regs_hold: assert property (
    frame_select_n_i [*8] |-> $stable({xtal_warp_trim_o,
                                       clock_output_select_o}))
    else $error("control changed outside a frame");
  a_end_idle: assert property (
    frame_select_n_i [*8] |-> !busy_o)
    else $error("busy after frame end");
  a_start_busy: assert property (
    (frame_select_n_i && port_awake_i) [*4] ##1
    (!frame_select_n_i && port_awake_i) [*7] |-> busy_o)
    else $error("frame start not taken");
  a_sleep_deaf: assert property (
    (frame_select_n_i && !port_awake_i) [*8] ##1 !port_awake_i [*8]
    |-> !busy_o)
    else $error("port answered while asleep");
  a_fall_change: assert property (
    $changed(serial_data_o) && $past(serial_data_oe_o) && serial_data_oe_o
    |-> !$past(serial_shift_clock_i, 2))
    else $error("data out moved outside clock low phase");
endmodule : rmsp_checker

bind rmsp_spi_slave rmsp_checker u_rmsp_checker (
  .mclk_i, .sys_rst_i, .serial_shift_clock_i, .frame_select_n_i,
  .serial_data_o, .serial_data_oe_o, .port_awake_i, .xtal_warp_trim_o,
  .clock_output_select_o, .reference_clock_output_undivided_o, .busy_o);

// ===== rmsp_sync.sv
`timescale 1ns/100ps

module rmsp_sync
  import rmsp_pkg::*;
(
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // Raw pin and filtered level
  input  wire logic din_i,
  output logic      level_o
);

  logic s1;
  logic s2;
  logic s3;

  // Three stages; level moves only when stages two and three agree
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s1      <= 1'b0;
      s2      <= 1'b0;
      s3      <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1 <= din_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end

endmodule : rmsp_sync

// ===== test_radio_modem_spi_slave_port.sv
`timescale 1ns/100ps
module test_radio_modem_spi_slave_port;
  import rmsp_pkg::*;
  logic        mclk_i, sys_rst_i, port_awake_i;
  logic        sck, cs_n, mosi, miso, miso_oe;
  logic [7:0]  trim;
  logic [2:0]  sel;
  logic        undiv, busy, short_f;
  logic [31:0] rd;
  int          errors, check_count;
  // Released line shows the inverse, so a missing enable is caught
  wire         miso_line = miso_oe ? miso : ~miso;
  rmsp_spi_slave u_rmsp_spi_slave (
    .mclk_i, .sys_rst_i, .serial_shift_clock_i(sck),
    .frame_select_n_i(cs_n), .serial_data_i(mosi), .serial_data_o(miso),
    .serial_data_oe_o(miso_oe), .port_awake_i, .xtal_warp_trim_o(trim),
    .clock_output_select_o(sel),
    .reference_clock_output_undivided_o(undiv), .busy_o(busy),
    .short_frame_o(short_f));
  rmsp_host_model u_rmsp_host_model (
    .mclk_i, .serial_shift_clock_o(sck), .frame_select_n_o(cs_n),
    .serial_data_o(mosi), .serial_data_i(miso_line));
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic regs(input logic [7:0] et, input logic [2:0] es);
    check("trim", {24'h0, trim}, {24'h0, et});
    check("select", {29'h0, sel}, {29'h0, es});
    check("undivided", {31'h0, undiv}, {31'h0, es == 3'h0});
    check("busy", {31'h0, busy}, 32'h0);
  endtask : regs
  task automatic xf(input logic [7:0] h, input int n, input logic [31:0] w);
    u_rmsp_host_model.xfer(h, n, w, rd);
  endtask : xf
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  // Watchdog, a few times the expected run length
  initial begin
    repeat (30000) @(posedge mclk_i);
    errors++;
    complete_run();
  end
  // Values straight out of reset
  task automatic test_reset;
    regs(8'h00, 3'h0);
    check("oe", {31'h0, miso_oe}, 32'h0);
    $display("reset test done");
  endtask : test_reset
  // Write, read back, reserved header bit set
  task automatic test_write_read;
    xf(8'h0A, 2, 32'hABCD_0000);
    regs(8'hAB, 3'h5);
    xf(8'h8A, 2, 32'h0);
    check("read", rd, 32'h0000_ABCD);
    xf(8'hCA, 2, 32'h0);
    check("read rsv", rd, 32'h0000_ABCD);
    $display("write read test done");
  endtask : test_write_read
  // Long frame runs into an unmapped address
  task automatic test_long;
    xf(8'h0A, 4, 32'h1122_3344);
    regs(8'h11, 3'h2);
    xf(8'h8A, 4, 32'h0);
    check("read long", rd, 32'h1122_0000);
    $display("long frame test done");
  endtask : test_long
  // Extreme trim with undivided select, unmapped accesses refused
  task automatic test_refuse;
    xf(8'h0A, 2, 32'hFF00_0000);
    regs(8'hFF, 3'h0);
    xf(8'h0B, 2, 32'h1234_0000);
    regs(8'hFF, 3'h0);
    xf(8'h8B, 2, 32'h0);
    check("unmapped", rd, 32'h0);
    $display("refuse test done");
  endtask : test_refuse
  // Asleep port ignores the whole frame; sleep starts well before it
  task automatic test_sleep;
    port_awake_i = 1'b0;
    repeat (10) @(negedge mclk_i);
    xf(8'h0A, 2, 32'h5A5A_0000);
    regs(8'hFF, 3'h0);
    port_awake_i = 1'b1;
    $display("sleep test done");
  endtask : test_sleep
  // Frame of two bursts only
  task automatic test_short;
    xf(8'h0A, 1, 32'h3300_0000);
    check("short", {31'h0, short_f}, 32'h1);
    regs(8'hFF, 3'h0);
    xf(8'h8A, 2, 32'h0);
    check("short clr", {31'h0, short_f}, 32'h0);
    check("read", rd, 32'h0000_FF00);
    $display("short frame test done");
  endtask : test_short
  // Mid-run reset clears the register and the status of a cut frame
  task automatic test_mid_reset;
    xf(8'h0A, 1, 32'h0);
    check("short set", {31'h0, short_f}, 32'h1);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    regs(8'h00, 3'h0);
    check("short rst", {31'h0, short_f}, 32'h0);
    check("oe rst", {31'h0, miso_oe}, 32'h0);
    xf(8'h8A, 2, 32'h0);
    check("read rst", rd, 32'h0);
    $display("mid reset test done");
  endtask : test_mid_reset
  initial begin
    sys_rst_i = 1'b1;
    port_awake_i = 1'b1;
    errors = 0;
    check_count = 0;
    repeat (12) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    test_reset();
    test_write_read();
    test_long();
    test_refuse();
    test_sleep();
    test_short();
    test_mid_reset();
    complete_run();
  end
endmodule : test_radio_modem_spi_slave_port
